// ---- design/afr_top.sv ----
/*
 Serial readout side of an ADC result FIFO, plus an 8-bit register load path.
 Assumes cs_n, sclk and din come from a host master on another clock; the
 converter core delivers 10-bit results as one-cycle pulses on ref_clk.
*/
// Overview of operation
// [RL1] Short first byte: next byte continues entry
// [RL2] Short second byte: drop entry remainder
// [RL3] Other stored entries stay intact
// [RL4] Host ignores four leading bits afterward
// [RL5] Short write updates MSB-first bits only
// [RL6] Early chip select aborts conversion, corrupts
// [RL7] Results are straight unsigned binary
// [RL8] Four zeros, ten data, two zeros
// [RL9] Sample on rising, shift on falling
// [RL10] Scan done drives end flag low
// [RL11] Full read advances to next entry
module afr_top
    import afr_pkg::*;
#(
    parameter int DEPTH = AFR_FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    input wire logic res_valid,
    input wire logic [AFR_RESULT_W-1:0] res_data,
    input wire logic scan_start,
    input wire logic scan_last,
    input wire logic [AFR_REG_W-1:0] reg_sel,
    output logic dout,
    output logic eoc_n,
    output logic conv_abort,
    output logic [AFR_REG_W-1:0] cfg_out
);
    localparam int AW = $clog2(DEPTH);

    // Pointers wrap by their width, so the depth must be a power of two
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("DEPTH must be a power of two of at least 2");
    end

    function automatic logic [AW:0] ptr_inc(input logic [AW:0] ptr);
        return ptr + (AW + 1)'(1);
    endfunction

    function automatic logic edge_up(input logic was, input logic now);
        return !was && now;
    endfunction

    function automatic logic edge_down(input logic was, input logic now);
        return was && !now;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Synchronisers: first stage read only by second
    logic [1:0] cs_sync_reg, sclk_sync_reg, din_sync_reg;
    logic cs_d_reg, sclk_d_reg;

    always_ff @(posedge ref_clk) begin
        cs_sync_reg <= {cs_sync_reg[0], cs_n};
        sclk_sync_reg <= {sclk_sync_reg[0], sclk};
        din_sync_reg <= {din_sync_reg[0], din};
        cs_d_reg <= cs_sync_reg[1];
        sclk_d_reg <= sclk_sync_reg[1];
    end

    wire cs_low = ~cs_sync_reg[1];
    wire cs_fall = edge_down(cs_d_reg, cs_sync_reg[1]);
    wire cs_rise = edge_up(cs_d_reg, cs_sync_reg[1]);
    // Gated by select, so a serial clock running between frames is harmless
    wire sclk_rise = cs_low & edge_up(sclk_d_reg, sclk_sync_reg[1]);
    wire sclk_fall = cs_low & edge_down(sclk_d_reg, sclk_sync_reg[1]);

    ////////////////////////////////////////////////////////////////////
    // Conversion status
    afr_conv_t conv_reg, conv_next;
    logic [AW:0] wr_ptr_reg, rd_ptr_reg;
    wire fifo_empty = (wr_ptr_reg == rd_ptr_reg);
    wire fifo_full = (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]) &&
                     (wr_ptr_reg[AW] != rd_ptr_reg[AW]);
    wire early_cs = cs_fall && (conv_reg == AFR_BUSY);
    // Code is plain binary, one step per VREF/1024: passed unchanged
    // A full store drops new results; the scan still ends
    wire wr_en = res_valid && (conv_reg == AFR_BUSY) && !fifo_full; // RL7

    always_comb begin
        conv_next = conv_reg;
        case (conv_reg)
            AFR_IDLE: begin
                if (scan_start) begin
                    conv_next = AFR_BUSY;
                end
            end
            AFR_BUSY: begin
                if (early_cs) begin
                    conv_next = AFR_IDLE; // RL6
                end else if (res_valid && scan_last) begin
                    conv_next = AFR_DONE; // RL10
                end
            end
            AFR_DONE: begin
                if (cs_fall) begin
                    conv_next = AFR_IDLE;
                end else if (scan_start) begin
                    conv_next = AFR_BUSY;
                end
            end
            default: conv_next = AFR_IDLE;
        endcase
    end

    // Abort empties the store: the corruption kept easy to recognise
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            conv_reg <= AFR_IDLE;
            wr_ptr_reg <= '0;
            eoc_n <= 1'b1;
            conv_abort <= 1'b0;
        end else begin
            conv_reg <= conv_next;
            eoc_n <= (conv_next != AFR_DONE); // RL10
            conv_abort <= early_cs; // RL6
            if (early_cs) begin
                wr_ptr_reg <= rd_ptr_reg; // RL6
            end else if (wr_en) begin
                wr_ptr_reg <= ptr_inc(wr_ptr_reg);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Result store
    logic [AFR_ENTRY_W-1:0] rd_word;

    afr_mem #(.WIDTH(AFR_ENTRY_W), .DEPTH(DEPTH)) u_mem (
        .ref_clk(ref_clk),
        .wr_en(wr_en),
        .wr_addr(wr_ptr_reg[AW-1:0]),
        .wr_data(afr_pack(res_data)), // RL8
        .rd_addr(rd_ptr_reg[AW-1:0]),
        .rd_data(rd_word)
    );

    ////////////////////////////////////////////////////////////////////
    // Readout shifter
    logic [AFR_ENTRY_W-1:0] shift_reg;
    logic [4:0] bit_cnt_reg;
    logic loaded_reg;
    logic [AFR_REG_W-1:0] in_reg, cfg_reg;
    logic [3:0] in_cnt_reg;

    wire entry_open = loaded_reg && bit_cnt_reg != 5'h00;
    wire entry_done = sclk_fall && loaded_reg && bit_cnt_reg == 5'(AFR_ENTRY_W - 1);
    // Cut during first byte keeps the entry open; the next byte continues it
    wire entry_cut = cs_rise && entry_open && bit_cnt_reg < 5'(AFR_BYTE_W);
    // A cut on the byte boundary leaves the second byte whole for the next frame
    wire drop_short = cs_rise && entry_open && bit_cnt_reg > 5'(AFR_BYTE_W); // RL2
    wire entry_resume = cs_fall && entry_open;
    wire pop = entry_done | drop_short; // RL11

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rd_ptr_reg <= '0;
            loaded_reg <= 1'b0;
            bit_cnt_reg <= 5'd0;
            shift_reg <= '0;
            dout <= 1'b0;
        end else begin
            if (pop) begin
                rd_ptr_reg <= ptr_inc(rd_ptr_reg); // RL3
                loaded_reg <= 1'b0;
                bit_cnt_reg <= 5'd0; // RL11
            end else if (cs_fall && !fifo_empty && !entry_open) begin
                loaded_reg <= 1'b1;
                shift_reg <= rd_word;
                dout <= rd_word[AFR_ENTRY_W-1]; // RL8
                bit_cnt_reg <= 5'd0;
            end else if (entry_cut) begin
                // No shift: the next byte starts at the first unread bit
                bit_cnt_reg <= 5'(AFR_BYTE_W); // RL1
            end else if (entry_resume) begin
                dout <= shift_reg[AFR_ENTRY_W-1]; // RL1
            end else if (sclk_fall && loaded_reg) begin
                shift_reg <= {shift_reg[AFR_ENTRY_W-2:0], 1'b0}; // RL9
                dout <= shift_reg[AFR_ENTRY_W-2];
                bit_cnt_reg <= bit_cnt_reg + 5'd1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register write path: MSB first, partial writes keep low bits
    wire reg_commit = cs_rise && in_cnt_reg != 4'h0 && reg_sel != 8'h00;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            in_reg <= AFR_REG_RESET;
            in_cnt_reg <= 4'h0;
        end else if (cs_fall) begin
            in_cnt_reg <= 4'h0;
            in_reg <= cfg_reg;
        end else if (sclk_rise && in_cnt_reg != 4'(AFR_REG_W)) begin
            in_reg[3'(AFR_REG_W - 1 - int'(in_cnt_reg))] <= din_sync_reg[1]; // RL9
            in_cnt_reg <= in_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cfg_reg <= AFR_REG_RESET;
            cfg_out <= AFR_REG_RESET;
        end else begin
            cfg_out <= cfg_reg;
            if (reg_commit) begin
                // Commit at deselect so a cut write never shows half-shifted
                cfg_reg <= in_reg; // RL5
            end
        end
    end
endmodule

// ---- common/afr_pkg.sv ----
/*
 Shared constants for the ADC FIFO serial readout block.
 Assumes one 250 MHz core clock and a slow serial link sampled by it.
*/
package afr_pkg;
    localparam int AFR_RESULT_W = 10;
    localparam int AFR_ENTRY_W = 16;
    localparam int AFR_LEAD_ZEROS = 4;
    localparam int AFR_TRAIL_ZEROS = 2;
    localparam int AFR_BYTE_W = 8;
    localparam int AFR_FIFO_DEPTH = 16;
    localparam int AFR_REG_W = 8;
    localparam int AFR_CODE_STEPS = 1024;
    localparam logic [7:0] AFR_REG_RESET = 8'h00;

    typedef enum logic [1:0] {
        AFR_IDLE = 2'b00,
        AFR_BUSY = 2'b01,
        AFR_DONE = 2'b11
    } afr_conv_t;

    function automatic logic [15:0] afr_pack(input logic [9:0] res);
        afr_pack = {4'h0, res, 2'h0};
    endfunction
endpackage

// ---- design/afr_mem.sv ----
/*
 Small result store with registered read data.
 Assumes a single clock; write and read ports are independent.
*/
module afr_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem_reg [DEPTH];

    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
        rd_data <= mem_reg[rd_addr];
    end
endmodule

// ---- test/afr_top_chk.sv ----
/* Pin assertions for the readout block.
   Bound to afr_top; sees its ports only. */
module afr_top_chk (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic scan_start,
    input wire logic scan_last,
    input wire logic dout,
    input wire logic eoc_n,
    input wire logic conv_abort,
    input wire logic [7:0] cfg_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Select syncs take about three cycles; six quiet ones are settled
    sequence cs_idle;
        cs_n [*6];
    endsequence
    chk_eoc_hold: assert property ((cs_n && !eoc_n && !scan_start) [*3] |=> !eoc_n)
        else $error("end flag left low state early");
    chk_eoc_cause: assert property ($fell(eoc_n) |->
        $past(scan_last) || $past(scan_last, 2) || $past(scan_last, 3))
        else $error("end flag fell without last result");
    chk_start_busy: assert property (scan_start |=> eoc_n)
        else $error("end flag low during scan");
    chk_abort_cause: assert property (conv_abort |->
        !$past(cs_n, 2) || !$past(cs_n, 3) || !$past(cs_n, 4))
        else $error("abort without select");
    chk_abort_pulse: assert property (conv_abort |=> !conv_abort)
        else $error("abort longer than a cycle");
    chk_abort_busy: assert property (conv_abort |-> eoc_n)
        else $error("abort after scan end");
    chk_cfg_hold: assert property (cs_idle |=> $stable(cfg_out))
        else $error("register moved while deselected");
    chk_dout_quiet: assert property (cs_idle |=> $stable(dout))
        else $error("serial out moved while deselected");
endmodule
bind afr_top afr_top_chk u_afr_top_chk (.ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n),
    .scan_start(scan_start), .scan_last(scan_last), .dout(dout), .eoc_n(eoc_n),
    .conv_abort(conv_abort), .cfg_out(cfg_out));

// ---- test/afr_host.sv ----
/* Host master model, clock phase zero, 32 ns serial clock.
   Runs off the bench clock; sclk stands low between frames. */
module afr_host (
    input wire logic ref_clk,
    input wire logic dout,
    output logic cs_n = 1'b1,
    output logic sclk = 1'b0,
    output logic din = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic xfer(input int n, input logic [15:0] w, output logic [15:0] r);
        r = 16'h0000;
        cs_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        for (int i = 0; i < n; i++) begin
            din <= w[15 - i];
            repeat (4) @(posedge ref_clk);
            sclk <= 1'b1;
            repeat (4) @(posedge ref_clk);
            // Taken late in the high phase, where the device still holds it
            r[15 - i] = dout;
            sclk <= 1'b0;
        end
        repeat (4) @(posedge ref_clk);
        cs_n <= 1'b1;
        din <= ~din;
        repeat (8) @(posedge ref_clk);
    endtask
endmodule

// ---- test/adc_fifo_serial_readout_test.sv ----
/* Bench: register writes, full and cut reads, aborted scan.
   Host pins come from afr_host; checker is bound to afr_top. */
module adc_fifo_serial_readout_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic res_valid = 1'b0;
    logic scan_start = 1'b0;
    logic scan_last = 1'b0;
    logic [9:0] res_data = 10'h000;
    logic [7:0] reg_sel = 8'h00;
    logic cs_n, sclk, din, dout, eoc_n, conv_abort;
    logic [7:0] cfg_out;
    logic [15:0] rd;
    int n_fail = 0;
    int n_compared = 0;
    int n_abort = 0;
    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (conv_abort === 1'b1) n_abort++;
    afr_top u_afr_top (.ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk),
        .din(din), .res_valid(res_valid), .res_data(res_data), .scan_start(scan_start),
        .scan_last(scan_last), .reg_sel(reg_sel), .dout(dout), .eoc_n(eoc_n),
        .conv_abort(conv_abort), .cfg_out(cfg_out));
    afr_host u_afr_host (.ref_clk(ref_clk), .dout(dout), .cs_n(cs_n), .sclk(sclk), .din(din));
    ////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    function automatic logic [15:0] ent(input logic [9:0] a, input int i);
        return {4'h0, a + 10'(i * 37), 2'h0};
    endfunction
    task automatic scan(input logic [9:0] a, input int n);
        int i;
        scan_start <= 1'b1;
        @(posedge ref_clk);
        scan_start <= 1'b0;
        for (i = 0; i < n; i++) begin
            res_valid <= 1'b1;
            res_data <= a + 10'(i * 37);
            scan_last <= (i == n - 1);
            @(posedge ref_clk);
        end
        res_valid <= 1'b0;
        scan_last <= 1'b0;
        // Host must not select before the end flag
        for (i = 0; i < 100 && eoc_n !== 1'b0; i++) @(posedge ref_clk);
        check("eoc", {15'h0, eoc_n}, 16'h0000);
    endtask
    task automatic t_write;
        reg_sel <= 8'h01;
        u_afr_host.xfer(8, 16'hA500, rd);
        check("cfg full", {8'h00, cfg_out}, 16'h00A5);
        u_afr_host.xfer(3, 16'h4000, rd);
        check("cfg cut", {8'h00, cfg_out}, 16'h0045);
        reg_sel <= 8'h00;
        $display("write done");
    endtask
    task automatic t_reads;
        logic [15:0] e;
        scan(10'h3FF, 2);
        for (int i = 0; i < 2; i++) begin
            u_afr_host.xfer(16, 16'h0000, rd);
            check("entry", rd, ent(10'h3FF, i));
        end
        scan(10'h155, 4);
        e = ent(10'h155, 0);
        u_afr_host.xfer(5, 16'h0000, rd);
        check("cut first", rd & 16'hF800, e & 16'hF800);
        u_afr_host.xfer(8, 16'h0000, rd);
        check("next eight", {8'h00, rd[15:8]}, {8'h00, e[10:3]});
        u_afr_host.xfer(16, 16'h0000, rd);
        check("after cut", rd & 16'h0FFF, ent(10'h155, 1) & 16'h0FFF);
        u_afr_host.xfer(12, 16'h0000, rd);
        check("cut second", rd & 16'hFFF0, ent(10'h155, 2) & 16'hFFF0);
        u_afr_host.xfer(16, 16'h0000, rd);
        check("last", rd & 16'h0FFF, ent(10'h155, 3) & 16'h0FFF);
        check("cfg kept", {8'h00, cfg_out}, 16'h0045);
        $display("reads done");
    endtask
    task automatic t_abort;
        scan_start <= 1'b1;
        @(posedge ref_clk);
        scan_start <= 1'b0;
        u_afr_host.xfer(0, 16'h0000, rd);
        check("abort", 16'(n_abort), 16'h0001);
        check("no end", {15'h0, eoc_n}, 16'h0001);
        $display("abort done");
    endtask
    initial begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        t_write;
        t_reads;
        t_abort;
        test_done;
    end
    // About fifteen times the expected run
    initial begin
        #60000;
        n_fail++;
        test_done;
    end
endmodule
